/* sim/scr_regs_props.sv */
`timescale 1ns/1ns
module scr_props
(
   // clock and reset
   input logic       clk,
   input logic       srst,
   // register port
   input logic       reg_wr,
   input logic [7:0] reg_addr,
   input logic [7:0] reg_wdata,
   input logic [7:0] reg_rdata,
   // controls
   input logic       aux_audio_wr,
   input logic       aux_audio_wval,
   input logic       repeater_mode,
   input logic       inband_surround_valid,
   input logic       inband_surround,
   input logic       scl_low_start,
   // outputs
   input logic       scl_low_busy,
   input logic       scl_low_done,
   input logic [7:0] scl_low_time,
   input logic       wide_format_mode,
   input logic       surround_audio,
   input logic       aux_audio_enable
);
   logic [9:0] n_q;
   logic [9:0] n_d;
   // busy cycle count
   always_comb
   begin
      n_d = scl_low_busy ? n_q + 10'h001 : 10'h000;
   end
   always_ff @(posedge clk)
   begin
      n_q <= srst ? 10'h000 : n_d;
   end
   default clocking @(posedge clk); endclocking
   default disable iff (srst);
   property p_rst; $past(srst) |-> scl_low_time == 8'h7F; endproperty
   property p_wlow; reg_wr && reg_addr == 8'h19 |=>
      scl_low_time == $past(reg_wdata); endproperty
   property p_go; scl_low_start && !scl_low_busy |=> scl_low_busy;
   endproperty
   property p_len; scl_low_done |->
      n_q == {1'b0, scl_low_time, 1'b0} + 10'h00A; endproperty
   property p_wide; reg_wr && reg_addr == 8'h1A |=>
      wide_format_mode == $past(reg_wdata[1]); endproperty
   property p_dp; reg_addr == 8'h1A |=> reg_rdata[7:1] ==
      {4'h0, $past(aux_audio_enable), 1'b0, $past(wide_format_mode)};
   endproperty
   property p_ovr; repeater_mode && inband_surround_valid |->
      surround_audio == inband_surround; endproperty
   property p_aux; aux_audio_wr |=>
      aux_audio_enable == $past(aux_audio_wval); endproperty
   property p_pin2; reg_addr == 8'h1D |=> reg_rdata[7:1] == 7'h00;
   endproperty
   a_rst: assert property (p_rst) else $error("low time reset");
   a_wlow: assert property (p_wlow) else $error("low time write");
   a_go: assert property (p_go) else $error("timer start");
   a_len: assert property (p_len) else $error("low phase length");
   a_wide: assert property (p_wide) else $error("wide mode");
   a_dp: assert property (p_dp) else $error("data path read");
   a_ovr: assert property (p_ovr) else $error("override");
   a_aux: assert property (p_aux) else $error("aux enable");
   a_pin2: assert property (p_pin2) else $error("reserved bits");
   c_done: cover property (scl_low_done);
   c_ovr: cover property (repeater_mode && inband_surround_valid);
   c_aux: cover property (aux_audio_wr);
endmodule
bind scr_regs scr_props u_props (.*);

/* sim/tb_top.sv */
`timescale 1ns/1ns
`define CHK(a,e) begin checks++; if ((a) !== (e)) begin err_count++; \
$display("unexpected at %0t got %h exp %h", $time, a, e); end end
module tb_top;
   logic clk = 0, srst = 1, reg_wr = 0, second_port_select = 0;
   logic aux_audio_wr = 0, aux_audio_wval = 0, mode_strap_pin_zero = 1;
   logic repeater_mode = 0, inband_surround_valid = 0, inband_surround = 0;
   logic self_test_start = 0, bc_err_clear = 0, scl_low_start = 0;
   logic link_one_crc_err = 0, link_two_crc_err = 0, pin_eight_input = 1;
   logic pin_five_input = 1, pin_six_input = 0, pin_seven_input = 1;
   logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, rv;
   logic [3:0] pin_low_inputs = 4'hA, link_two_pin_inputs = 4'h5;
   logic [7:0] scl_low_time;
   logic scl_low_busy, scl_low_done, wide_format_mode;
   logic surround_audio, aux_audio_enable;
   int err_count = 0, checks = 0, cyc = 0;
   scr_regs u_dut (.*);
   // clock and hang limit
   initial forever #10 clk = ~clk;
   always @(posedge clk)
   begin
      cyc++;
      if (cyc == 3000)
      begin
         err_count++;
         give_verdict;
      end
   end
   task give_verdict;
      $display("checks %0d errors %0d", checks, err_count);
      if (err_count == 0 && checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   task wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge clk);
      {reg_wr, reg_addr, reg_wdata} = {1'b1, a, d};
      @(negedge clk);
      reg_wr = 0;
   endtask
   task rd(input logic [7:0] a);
      @(negedge clk);
      reg_addr = a;
      @(negedge clk);
      rv = reg_rdata;
   endtask
   task ev(input int n, input logic two);
      @(negedge clk);
      {link_one_crc_err, link_two_crc_err} = {!two, two};
      repeat (n) @(negedge clk);
      {link_one_crc_err, link_two_crc_err} = 2'b00;
   endtask
   task t_low;
      int n;
      rd(8'h19); `CHK(rv, 8'h7F)
      wr(8'h19, 8'h03);
      wr(8'h1B, 8'h55);
      rd(8'h19); `CHK(rv, 8'h03)
      @(negedge clk) scl_low_start = 1;
      @(negedge clk) scl_low_start = 0;
      n = 0;
      while (scl_low_busy === 1'b1)
      begin
         n++;
         scl_low_start = (n == 3);
         @(negedge clk);
      end
      `CHK(scl_low_done, 1'b1)
      `CHK(n, 16)
   endtask
   task t_path;
      rd(8'h1A); `CHK(rv, 8'h08)
      wr(8'h1A, 8'hFF);
      rd(8'h1A); `CHK(rv, 8'h0B)
      `CHK({wide_format_mode, surround_audio}, 2'b11)
      @(negedge clk) aux_audio_wr = 1;
      @(negedge clk) aux_audio_wr = 0;
      {repeater_mode, inband_surround_valid} = 2'b11;
      rd(8'h1A); `CHK(rv, 8'h03)
      `CHK(surround_audio, 1'b0)
      repeater_mode = 0;
      wr(8'h1A, 8'h00);
      rd(8'h1A); `CHK({rv, wide_format_mode, surround_audio}, 10'h0)
   endtask
   task t_cnt;
      rd(8'h1B); `CHK(rv, 8'h00)
      ev(3, 0);
      ev(2, 1);
      rd(8'h1B); `CHK(rv, 8'h03)
      second_port_select = 1;
      rd(8'h1B); `CHK(rv, 8'h02)
      ev(300, 1);
      rd(8'h1B); `CHK(rv, 8'hFF)
      @(negedge clk) {bc_err_clear, link_two_crc_err} = 2'b11;
      @(negedge clk) {bc_err_clear, link_two_crc_err} = 2'b00;
      rd(8'h1B); `CHK(rv, 8'h01)
      @(negedge clk) self_test_start = 1;
      @(negedge clk) self_test_start = 0;
      second_port_select = 0;
      rd(8'h1B); `CHK(rv, 8'h00)
   endtask
   task t_pins;
      // pins held as inputs while read
      wr(8'h1C, 8'hFF);
      rd(8'h1C); `CHK(rv, 8'hAA)
      rd(8'h1D); `CHK(rv, 8'h01)
      second_port_select = 1;
      pin_five_input = 0;
      repeat (3) @(negedge clk);
      rd(8'h1C); `CHK(rv, 8'h85)
      wr(8'h20, 8'hFF);
      rd(8'h20); `CHK(rv, 8'h00)
   endtask
   // reset then scenarios
   initial
   begin
      repeat (3) @(posedge clk);
      @(negedge clk) srst = 0;
      t_low;
      t_path;
      t_cnt;
      t_pins;
      give_verdict;
   end
endmodule

/* verilog/scr_low_timer.sv */
`timescale 1ns/1ns
// counts oscillator steps while a low phase is requested
module scr_low_timer
(
   // clock and reset
   input  wire logic       clk,
   input  wire logic       srst,
   // control
   input  wire logic       start,
   input  wire logic [7:0] low_time,
   // status
   output logic            busy,
   output logic            done
);
   logic       div_q, div_d;
   logic [8:0] cnt_q, cnt_d;
   logic       busy_q, busy_d;
   logic       done_q, done_d;

   // next-state for the low-phase counter
   always_comb
   begin
      div_d  = div_q;
      cnt_d  = cnt_q;
      busy_d = busy_q;
      done_d = 1'b0;
      if (start && !busy_q)
      begin
         busy_d = 1'b1;
         div_d  = 1'b0;
         cnt_d  = {1'b0, low_time} + scr_pkg::SCL_EXTRA_CYC;
      end
      else if (busy_q)
      begin
         div_d = ~div_q;           // one step per OSC_DIV_CYC clocks
         if (div_q)
         begin
            if (cnt_q == 9'h001)
            begin
               busy_d = 1'b0;
               done_d = 1'b1;
            end
            cnt_d = cnt_q - 9'h001;
         end
      end
   end

   // registers
   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         div_q  <= 1'b0;
         cnt_q  <= 9'h000;
         busy_q <= 1'b0;
         done_q <= 1'b0;
      end
      else
      begin
         div_q  <= div_d;
         cnt_q  <= cnt_d;
         busy_q <= busy_d;
         done_q <= done_d;
      end
   end

   assign busy = busy_q;
   assign done = done_q;
endmodule

/* verilog/scr_pkg.sv */
package scr_pkg;
   // register offsets
   localparam logic [7:0] OFS_SCL_LOW   = 8'h19;
   localparam logic [7:0] OFS_DATA_PATH = 8'h1A;
   localparam logic [7:0] OFS_BC_ERR    = 8'h1B;
   localparam logic [7:0] OFS_PIN_ONE   = 8'h1C;
   localparam logic [7:0] OFS_PIN_TWO   = 8'h1D;
   // reset and saturation values
   localparam logic [7:0] SCL_LOW_RST   = 8'h7F;
   localparam logic [7:0] BC_ERR_MAX    = 8'hFF;
   // data path field positions
   localparam int DP_SURROUND_BIT = 0;
   localparam int DP_WIDE_BIT     = 1;
   localparam int DP_AUX_BIT      = 3;
   // scl low timing: field + five extra oscillator cycles
   localparam logic [8:0] SCL_EXTRA_CYC = 9'h005;
   // oscillator step 40 ns at 50 MHz clk (20 ns) is two cycles
   localparam int OSC_STEP_NS  = 40;
   localparam int CLK_NS       = 20;
   localparam int OSC_DIV_CYC  = OSC_STEP_NS / CLK_NS;
endpackage

/* verilog/scr_regs.sv */
`timescale 1ns/1ns
// What this block does
// - master scl low width from field
// - same value sets slave sda setup
// - low time is field plus five steps
// - low-time field resets to 0x7F
// - data path bit 3 mirrors aux audio
// - aux enable taken from mode strap
// - bit 1 selects 28-bit or 24-bit
// - bit 0 clear gives stereo/quad audio
// - bit 0 set gives surround audio
// - repeater in-band detect may override surround
// - saturating back-channel crc error counter
// - counter clears on self-test start or clear
// - port select reads second link count
// - pin status five to seven, bit4 reserved
// - pins zero-three, second link when selected
// - port select steers access to link two
module scr_regs
(
   // clock and reset
   input  wire logic       clk,
   input  wire logic       srst,
   // register port
   input  wire logic       reg_wr,
   input  wire logic [7:0] reg_addr,
   input  wire logic [7:0] reg_wdata,
   output logic      [7:0] reg_rdata,
   // port select and aux audio control
   input  wire logic       second_port_select,
   input  wire logic       aux_audio_wr,
   input  wire logic       aux_audio_wval,
   input  wire logic       mode_strap_pin_zero,
   // audio mode override from repeater detection
   input  wire logic       repeater_mode,
   input  wire logic       inband_surround_valid,
   input  wire logic       inband_surround,
   // self-test error events
   input  wire logic       self_test_start,
   input  wire logic       bc_err_clear,
   input  wire logic       link_one_crc_err,
   input  wire logic       link_two_crc_err,
   // general-purpose pins (asynchronous)
   input  wire logic [3:0] pin_low_inputs,
   input  wire logic [3:0] link_two_pin_inputs,
   input  wire logic       pin_five_input,
   input  wire logic       pin_six_input,
   input  wire logic       pin_seven_input,
   input  wire logic       pin_eight_input,
   // scl timing
   input  wire logic       scl_low_start,
   output logic            scl_low_busy,
   output logic            scl_low_done,
   output logic [7:0]      scl_low_time,
   // data path controls
   output logic            wide_format_mode,
   output logic            surround_audio,
   output logic            aux_audio_enable
);
   // width of the pin synchroniser bank
   localparam int SYNC_W = 12;

   // control state
   logic [7:0]  scl_low_q, scl_low_d;
   logic        wide_q, wide_d;
   logic        surr_q, surr_d;
   logic        aux_q, aux_d;
   logic        strap_seen_q, strap_seen_d;
   logic [7:0]  err_one_q, err_one_d;
   logic [7:0]  err_two_q, err_two_d;
   logic [7:0]  rdata_q, rdata_d;
   // synchronised inputs
   logic [11:0] pin_raw;
   logic [11:0] pin_sync;
   logic [7:0]  pin_lvl;
   logic [3:0]  ln2_lvl;
   logic [1:0]  strap_sync_q;
   // write strobes and shared counter clear
   logic        wr_scl_low;
   logic        wr_data_path;
   logic        err_clr;
   // assembled read words
   logic [7:0]  rd_scl_low;
   logic [7:0]  rd_data_path;
   logic [7:0]  rd_bc_err;
   logic [7:0]  rd_pin_one;
   logic [7:0]  rd_pin_two;

   // saturating increment with clear priority below event
   function automatic logic [7:0] sat_cnt(input logic [7:0] c,
                                          input logic clr,
                                          input logic ev);
      logic [7:0] base;
      base = clr ? 8'h00 : c;
      if (ev && base != scr_pkg::BC_ERR_MAX)
         sat_cnt = base + 8'h01;
      else
         sat_cnt = base;
   endfunction

   // address match, shared by the write strobes
   function automatic logic hits(input logic [7:0] addr,
                                 input logic [7:0] ofs);
      hits = (addr == ofs);
   endfunction

   // write strobes; read-only offsets get none
   assign wr_scl_low   = reg_wr && hits(reg_addr, scr_pkg::OFS_SCL_LOW);
   assign wr_data_path = reg_wr && hits(reg_addr, scr_pkg::OFS_DATA_PATH);
   // self-test start and clear bit share one clear
   assign err_clr      = self_test_start | bc_err_clear;

   always_comb
   begin
      scl_low_d = scl_low_q;
      if (wr_scl_low)
         scl_low_d = reg_wdata;
   end

   // low time register
   always_ff @(posedge clk)
   begin
      if (srst)
         scl_low_q <= scr_pkg::SCL_LOW_RST;
      else
         scl_low_q <= scl_low_d;
   end

   // only bits 1 and 0 writable
   always_comb
   begin
      wide_d = wide_q;
      surr_d = surr_q;
      if (wr_data_path)
      begin
         wide_d = reg_wdata[scr_pkg::DP_WIDE_BIT];
         surr_d = reg_wdata[scr_pkg::DP_SURROUND_BIT];
      end
   end

   // data path registers
   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         wide_q <= 1'b0;
         surr_q <= 1'b0;
      end
      else
      begin
         wide_q <= wide_d;
         surr_q <= surr_d;
      end
   end

   always_comb
   begin
      aux_d        = aux_q;
      strap_seen_d = 1'b1;
      if (!strap_seen_q)
         aux_d = strap_sync_q[1];
      else if (aux_audio_wr)
         aux_d = aux_audio_wval;
   end

   // aux enable and strap-taken flag
   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         aux_q        <= 1'b0;
         strap_seen_q <= 1'b0;
      end
      else
      begin
         aux_q        <= aux_d;
         strap_seen_q <= strap_seen_d;
      end
   end

   always_comb
   begin
      err_one_d = sat_cnt(err_one_q, err_clr, link_one_crc_err);
      err_two_d = sat_cnt(err_two_q, err_clr, link_two_crc_err);
   end

   // back-channel error counters, one per link
   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         err_one_q <= 8'h00;
         err_two_q <= 8'h00;
      end
      else
      begin
         err_one_q <= err_one_d;
         err_two_q <= err_two_d;
      end
   end

   // read words; reserved bits tie to zero
   assign rd_scl_low   = scl_low_q;
   assign rd_data_path = {4'h0, aux_q, 1'b0, wide_q, surr_q};
   assign rd_bc_err    = second_port_select ? err_two_q : err_one_q;
   assign rd_pin_one   = {pin_lvl[7:5], 1'b0,
                          second_port_select ? ln2_lvl : pin_lvl[3:0]};
   assign rd_pin_two   = {7'h00, pin_lvl[4]};

   always_comb
   begin
      rdata_d = 8'h00;
      case (reg_addr)
         scr_pkg::OFS_SCL_LOW:   rdata_d = rd_scl_low;
         scr_pkg::OFS_DATA_PATH: rdata_d = rd_data_path;
         scr_pkg::OFS_BC_ERR:    rdata_d = rd_bc_err;
         scr_pkg::OFS_PIN_ONE:   rdata_d = rd_pin_one;
         scr_pkg::OFS_PIN_TWO:   rdata_d = rd_pin_two;
         default:                rdata_d = 8'h00;
      endcase
   end

   // registered read data, one cycle after the address
   always_ff @(posedge clk)
   begin
      if (srst)
         rdata_q <= 8'h00;
      else
         rdata_q <= rdata_d;
   end

   // gather pins; bit 4 carries pin eight, 11:8 link two
   assign pin_raw = {link_two_pin_inputs, pin_seven_input, pin_six_input,
                     pin_five_input, pin_eight_input, pin_low_inputs};

   // two-flop synchroniser for every pin bit
   for (genvar i = 0; i < SYNC_W; i = i + 1)
   begin : g_sync
      logic s1_q, s2_q;
      always_ff @(posedge clk)
      begin
         if (srst)
         begin
            s1_q <= 1'b0;
            s2_q <= 1'b0;
         end
         else
         begin
            s1_q <= pin_raw[i];
            s2_q <= s1_q;
         end
      end
      assign pin_sync[i] = s2_q;
   end

   // settled levels split by source
   assign pin_lvl = pin_sync[7:0];
   assign ln2_lvl = pin_sync[11:8];

   // strap synchroniser runs through reset, so the first edge
   // after release already sees a settled strap level
   always_ff @(posedge clk)
   begin
      strap_sync_q <= {strap_sync_q[0], mode_strap_pin_zero};
   end

   // shared low-phase timer
   // one timer serves master low phase and slave setup
   scr_low_timer u_timer
   (
      .clk      (clk),
      .srst     (srst),
      .start    (scl_low_start),
      .low_time (scl_low_q),
      .busy     (scl_low_busy),
      .done     (scl_low_done)
   );

   // register port, low time, wide format and aux enable outputs
   assign reg_rdata        = rdata_q;
   assign scl_low_time     = scl_low_q;
   assign wide_format_mode = wide_q;
   assign aux_audio_enable = aux_q;

   always_comb
   begin
      surround_audio = surr_q;
      if (repeater_mode && inband_surround_valid)
         surround_audio = inband_surround;
   end
endmodule
